// ==== rtl/ctv_pin_sync.sv ====
/*
  three-flop synchroniser for a group of pin inputs; a new level is taken
  once the second and third flops agree.
  assumes pins change slowly with respect to CLOCK.
*/
`timescale 1ns/1ps
module ctv_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic [WIDTH-1:0] PIN_IN,
  output logic [WIDTH-1:0] PIN_OUT
);

  // ****************************************************************
  // per-bit synchroniser
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      // first flop feeds only the second
      always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end else if (CLK_EN) begin
          s1_q <= PIN_IN[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign PIN_OUT[g] = lvl_q;
    end
  endgenerate

endmodule

// ==== rtl/ctv_pkg.sv ====
/*
  package of the termination/pre-charge and battery regulation registers:
  register addresses, field positions, reset values and clamp limits.
  assumes one clock domain and an 8-bit register access port.
*/
package ctv_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] TERM_PRECHARGE_CTRL_ADDR = 8'h04;
  localparam logic [7:0] BATT_REG_VOLTAGE_CTRL_ADDR = 8'h05;
  localparam logic [7:0] TERM_PRECHARGE_CTRL_RESET = 8'h0E;
  localparam logic [7:0] BATT_REG_VOLTAGE_CTRL_RESET = 8'h78;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int TERM_RANGE_SEL_BIT = 7;
  localparam int TERM_CODE_MSB = 6;
  localparam int TERM_CODE_LSB = 2;
  localparam int TERM_ENABLE_BIT = 1;
  localparam int SPARE_BIT = 0;
  localparam int BATT_CODE_MSB = 7;
  localparam int BATT_CODE_LSB = 1;

  // ****************************************************************
  // clamp limits
  // ****************************************************************
  // low range: 500 uA + 9 x 500 uA = 5 mA
  localparam logic [4:0] TERM_CODE_LOW_MAX = 5'h09;
  // 3.6 V + 105 x 10 mV = 4.65 V
  localparam logic [6:0] BATT_CODE_MAX = 7'h69;

  // ****************************************************************
  // pin synchroniser depth
  // ****************************************************************
  localparam int SYNC_STAGES = 3;

endpackage

// ==== rtl/ctv_regs.sv ====
/*
  termination/pre-charge and battery regulation voltage registers with
  write clamping and the termination qualifier.
  assumes the serial engine offers an 8-bit address/data port with
  one-cycle write and read strobes on CLOCK; loop status and resistor
  detect arrive asynchronously from the analog side.
*/
`timescale 1ns/1ps
module ctv_regs (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic INPUT_VOLTAGE_LOOP,
  input wire logic COOL_REDUCE,
  input wire logic EXT_TERM_RES,
  output logic TERM_RANGE_SEL,
  output logic [4:0] TERM_CURRENT_CODE,
  output logic TERM_ACTIVE,
  output logic TERM_SRC_EXT,
  output logic [6:0] BATT_REG_CODE
);

  // ****************************************************************
  // decode and clamp
  // ****************************************************************
  logic [7:0] term_q;
  logic [7:0] term_d;
  logic [7:0] batt_q;
  logic [7:0] batt_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic range_q;
  logic [4:0] tcode_q;
  logic tact_q;
  logic text_q;
  logic [6:0] bcode_q;
  logic [1:0] pins_sync;
  logic ivl_s;
  logic cool_s;
  logic wr_term;
  logic wr_batt;
  logic [4:0] wcode_t;
  logic [6:0] wcode_b;
  logic [4:0] clamp_t;
  logic [6:0] clamp_b;
  logic inhibit;

  // address match, used for both write and read select
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  assign wr_term = REG_WR && hit(REG_ADDR, ctv_pkg::TERM_PRECHARGE_CTRL_ADDR);
  assign wr_batt = REG_WR &&
    hit(REG_ADDR, ctv_pkg::BATT_REG_VOLTAGE_CTRL_ADDR);
  assign wcode_t = REG_WDATA[ctv_pkg::TERM_CODE_MSB:ctv_pkg::TERM_CODE_LSB];
  assign wcode_b = REG_WDATA[ctv_pkg::BATT_CODE_MSB:ctv_pkg::BATT_CODE_LSB];
  // clamp at write time so readback shows the setting actually in force
  assign clamp_t = (!REG_WDATA[ctv_pkg::TERM_RANGE_SEL_BIT] &&
    (wcode_t > ctv_pkg::TERM_CODE_LOW_MAX)) ?
    ctv_pkg::TERM_CODE_LOW_MAX : wcode_t;
  assign clamp_b = (wcode_b > ctv_pkg::BATT_CODE_MAX) ?
    ctv_pkg::BATT_CODE_MAX : wcode_b;
  // range, enable and spare bit stored as written; code stored clamped
  assign term_d = wr_term ? {REG_WDATA[ctv_pkg::TERM_RANGE_SEL_BIT], clamp_t,
    REG_WDATA[ctv_pkg::TERM_ENABLE_BIT], REG_WDATA[ctv_pkg::SPARE_BIT]} :
    term_q;
  assign batt_d = wr_batt ? {clamp_b, REG_WDATA[ctv_pkg::SPARE_BIT]} :
    batt_q;
  // unmapped addresses read as zero
  assign rdata_d =
    hit(REG_ADDR, ctv_pkg::TERM_PRECHARGE_CTRL_ADDR) ? term_q :
    hit(REG_ADDR, ctv_pkg::BATT_REG_VOLTAGE_CTRL_ADDR) ? batt_q : 8'h00;
  assign ivl_s = pins_sync[0];
  assign cool_s = pins_sync[1];
  assign inhibit = ivl_s || cool_s;

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  ctv_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .CLOCK(CLOCK),
    .RSTN(RSTN),
    .CLK_EN(CLK_EN),
    .PIN_IN({COOL_REDUCE, INPUT_VOLTAGE_LOOP}),
    .PIN_OUT(pins_sync)
  );

  // resistor detect passes the same three-flop scheme
  logic [2:0] ext_sh_q;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ext_sh_q <= 3'h0;
    end else if (CLK_EN) begin
      ext_sh_q <= {ext_sh_q[1:0], EXT_TERM_RES};
    end
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  // register file, reset to power-on values
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      term_q <= ctv_pkg::TERM_PRECHARGE_CTRL_RESET;
      batt_q <= ctv_pkg::BATT_REG_VOLTAGE_CTRL_RESET;
    end else if (CLK_EN) begin
      term_q <= term_d;
      batt_q <= batt_d;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else if (CLK_EN) begin
      rvalid_q <= REG_RD;
      if (REG_RD) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // effective settings to the analog loops, one cycle behind storage
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      range_q <= 1'b0;
      tcode_q <= 5'h00;
      tact_q <= 1'b0;
      text_q <= 1'b0;
      bcode_q <= 7'h00;
    end else if (CLK_EN) begin
      range_q <= term_q[ctv_pkg::TERM_RANGE_SEL_BIT];
      tcode_q <= term_q[ctv_pkg::TERM_CODE_MSB:ctv_pkg::TERM_CODE_LSB];
      tact_q <= term_q[ctv_pkg::TERM_ENABLE_BIT] && !inhibit;
      if (ext_sh_q[1] == ext_sh_q[2]) begin
        text_q <= ext_sh_q[2];
      end
      bcode_q <= batt_q[ctv_pkg::BATT_CODE_MSB:ctv_pkg::BATT_CODE_LSB];
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;
  assign TERM_RANGE_SEL = range_q;
  assign TERM_CURRENT_CODE = tcode_q;
  assign TERM_ACTIVE = tact_q;
  assign TERM_SRC_EXT = text_q;
  assign BATT_REG_CODE = bcode_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  chk_term_low_clamp: assert property (
    CLK_EN && wr_term && !REG_WDATA[7] && REG_WDATA[6:2] > 5'h09
    |=> term_q[6:2] == 5'h09)
    else $error("low range termination code not clamped");
  chk_batt_clamp: assert property (
    CLK_EN && wr_batt && REG_WDATA[7:1] > 7'h69 |=> term_q == $past(term_q)
    && batt_q[7:1] == 7'h69)
    else $error("regulation code not clamped");
  chk_batt_pass: assert property (
    CLK_EN && wr_batt && REG_WDATA[7:1] <= 7'h69 ##1 CLK_EN
    |=> BATT_REG_CODE == $past(REG_WDATA, 2) >> 1)
    else $error("regulation code not passed through");
  chk_high_range: assert property (
    CLK_EN && wr_term && REG_WDATA[7] |=> term_q[7:2] == $past(REG_WDATA[7:2]))
    else $error("high range code altered");
  chk_spare_bits: assert property (
    CLK_EN && wr_term |=> term_q[0] == $past(REG_WDATA[0]))
    else $error("spare bit not stored");
  chk_term_inhibit: assert property (
    CLK_EN && inhibit |=> !TERM_ACTIVE)
    else $error("termination active under another loop");
  chk_term_enable: assert property (
    CLK_EN && !term_q[1] |=> !TERM_ACTIVE)
    else $error("termination active while disabled");
  chk_read_back: assert property (
    CLK_EN && REG_RD && hit(REG_ADDR, 8'h04) && !wr_term
    |=> REG_RVALID && REG_RDATA == $past(term_q))
    else $error("termination register readback wrong");
  chk_reg_hold: assert property (
    !CLK_EN |=> batt_q == $past(batt_q) && term_q == $past(term_q))
    else $error("registers changed while clock enable low");
  chk_batt_read_back: assert property (
    CLK_EN && REG_RD && hit(REG_ADDR, ctv_pkg::BATT_REG_VOLTAGE_CTRL_ADDR)
    |=> REG_RVALID && REG_RDATA == $past(batt_q))
    else $error("battery register readback wrong");

  // outputs never leave the clamped window, whatever the host wrote
  chk_low_code_cap: assert property (
    CLK_EN && !term_q[ctv_pkg::TERM_RANGE_SEL_BIT]
    |=> TERM_CURRENT_CODE <= ctv_pkg::TERM_CODE_LOW_MAX)
    else $error("low range termination code above cap");
  chk_batt_code_cap: assert property (
    CLK_EN |=> BATT_REG_CODE <= ctv_pkg::BATT_CODE_MAX)
    else $error("regulation code above cap");

endmodule

// ==== sim/charge_term_vbat_regs_tb.sv ====
/*
  testbench of the termination and battery regulation registers.
  assumes the host model drives the register port; pins driven here.
*/
`timescale 1ns/1ps
module charge_term_vbat_regs_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic in_loop = 1'b0;
  logic cool = 1'b0;
  logic ext_res = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic reg_wr, reg_rd, reg_rvalid, vld;
  logic range_sel, term_active, src_ext;
  logic [4:0] term_code;
  logic [6:0] batt_code;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] wa [7] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h05, 8'h05, 8'h05};
  logic [7:0] wd [7] = '{8'hFE, 8'h7F, 8'h24, 8'h28, 8'hD2, 8'hD4, 8'hFF};
  logic [7:0] we [7] = '{8'hFE, 8'h27, 8'h24, 8'h24, 8'hD2, 8'hD2, 8'hD3};
  logic [2:0] pins [3] = '{3'h4, 3'h2, 3'h1};

  always #5 clock = ~clock;

  ctv_regs DUT (.CLOCK(clock), .RSTN(rstn), .CLK_EN(clk_en),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .INPUT_VOLTAGE_LOOP(in_loop), .COOL_REDUCE(cool),
    .EXT_TERM_RES(ext_res), .TERM_RANGE_SEL(range_sel),
    .TERM_CURRENT_CODE(term_code), .TERM_ACTIVE(term_active),
    .TERM_SRC_EXT(src_ext), .BATT_REG_CODE(batt_code));

  ctv_host_model u_host (.CLOCK(clock), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid));

  // ****************************************************************
  // checks and closing
  // ****************************************************************
  task automatic cmp(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_cmp(input logic [7:0] addr, input logic [7:0] exp);
    u_host.read_reg(addr, rd, vld);
    cmp("read valid", 8'h01, {7'h00, vld});
    cmp("read data", exp, rd);
  endtask

  // outputs settle two edges after the strobe; three gives margin
  task automatic out_cmp(input logic rs, input logic [4:0] code,
                         input logic act, input logic [6:0] batt);
    repeat (3) @(posedge clock);
    #1;
    cmp("term setting", {rs, code, 2'h0}, {range_sel, term_code, 2'h0});
    cmp("term active", {7'h00, act}, {7'h00, term_active});
    cmp("regulation code", {1'b0, batt}, {1'b0, batt_code});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    rd_cmp(8'h04, 8'h0E);
    rd_cmp(8'h05, 8'h78);
    out_cmp(1'b0, 5'h03, 1'b1, 7'h3C);
    $display("test reset values done");
    // boundary and over-range codes; bit 0 must survive clamping
    for (int i = 0; i < 7; i++) begin
      u_host.write_reg(wa[i], wd[i]);
      rd_cmp(wa[i], we[i]);
    end
    out_cmp(1'b0, 5'h09, 1'b0, 7'h69);
    $display("test clamping done");
    u_host.prog_ext_current(8'h0A);
    rd_cmp(8'h03, 8'h00);
    rd_cmp(8'h04, 8'h0A);
    @(negedge clock);
    clk_en = 1'b0;
    u_host.write_reg(8'h04, 8'h00);
    @(negedge clock);
    clk_en = 1'b1;
    rd_cmp(8'h04, 8'h0A);
    $display("test unmapped and frozen access done");
    u_host.write_reg(8'h04, 8'hFE);
    out_cmp(1'b1, 5'h1F, 1'b1, 7'h69);
    // each loop pin alone inhibits; the resistor pin alone does not
    for (int i = 0; i < 3; i++) begin
      @(negedge clock);
      {in_loop, cool, ext_res} = pins[i];
      repeat (8) @(posedge clock);
      #1;
      cmp("term active", {7'h00, i == 2}, {7'h00, term_active});
      cmp("ext source", {7'h00, i == 2}, {7'h00, src_ext});
    end
    $display("test pin qualifiers done");
    complete_run();
  end
endmodule

// ==== sim/ctv_host_model.sv ====
/*
  host model: the serial controller side of the register port, one byte
  per strobe, strobes launched on the falling edge of CLOCK.
  assumes the block answers a read one enabled edge after the strobe.
*/
`timescale 1ns/1ps
module ctv_host_model (
  input wire logic CLOCK,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WR,
  output logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID
);
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  // idle bus starts quiet
  initial begin
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  end

  // a released bus shows the inverse, so a stale value never looks valid
  task automatic release_bus();
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = ~REG_ADDR;
    REG_WDATA = ~REG_WDATA;
  endtask

  // strobe held over exactly one rising edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge CLOCK);
    REG_ADDR = addr;
    REG_WDATA = data;
    REG_WR = 1'b1;
    @(negedge CLOCK);
    release_bus();
  endtask

  // answer taken mid-cycle, after the edge that samples the strobe
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic valid);
    @(negedge CLOCK);
    REG_ADDR = addr;
    REG_RD = 1'b1;
    @(negedge CLOCK);
    // valid stands for one cycle only, so take the answer before it drops
    data = REG_RDATA;
    valid = REG_RVALID;
    release_bus();
  endtask

  // pre-charge field goes in before the all-ones charge current code
  task automatic prog_ext_current(input logic [7:0] term);
    write_reg(8'h04, term);
    write_reg(8'h03, 8'hFC);
  endtask
endmodule
